// ===== logic/tpg_defs.svh
`ifndef TPG_DEFS_SVH
`define TPG_DEFS_SVH

// Register offsets
`define TPG_PATTERN_CONTROL_ADDR 16'h5E00
`define TPG_PATTERN_OPTIONS_ADDR 16'h5E01

// Reset values
`define TPG_PATTERN_CONTROL_RST  8'h00
`define TPG_PATTERN_OPTIONS_RST  8'h41

// pattern_control fields
`define TPG_CTL_ENABLE     7
`define TPG_CTL_ROLL       6
`define TPG_CTL_TRANSP     5
`define TPG_CTL_SQ_MONO    4
`define TPG_CTL_STYLE_HI   3
`define TPG_CTL_STYLE_LO   2
`define TPG_CTL_MODE_HI    1
`define TPG_CTL_MODE_LO    0

// pattern_options fields
`define TPG_OPT_CUT        6
`define TPG_OPT_LSB_CLR    5
`define TPG_OPT_SAME_SEED  4
`define TPG_OPT_SEED_HI    3
`define TPG_OPT_SEED_LO    0

// Random generator upper fill, keeps the shift register nonzero
`define TPG_SEED_FILL      12'hA5C
`define TPG_LFSR_RST       16'hA5C1

// Full-scale pixel
`define TPG_PIX_MAX        10'h3FF

`endif

// ===== logic/tpg_pkg.sv
package tpg_pkg;

  typedef enum logic [1:0] {
    TPG_BARS,
    TPG_RANDOM,
    TPG_SQUARE,
    TPG_BLACK
  } tpg_mode_t;

  typedef enum logic [1:0] {
    TPG_BAR_FLAT,
    TPG_BAR_TOP_DOWN,
    TPG_BAR_RIGHT_LEFT,
    TPG_BAR_BOTTOM_UP
  } tpg_style_t;

endpackage

// ===== logic/tpg_top.sv
`timescale 1ns/100ps
`include "tpg_defs.svh"

// ****************************************
// Output buffer
// ****************************************
module tpg_fifo #(
  parameter int W     = 12,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic         i_ref_clk,
  input  wire logic         i_rstn,
  // Fill side
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  // Drain side
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_q;
  logic [AW:0]  wr_d;
  logic [AW:0]  rd_q;
  logic [AW:0]  rd_d;
  logic         full;
  logic         empty;

  always_comb
  begin
    full  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    empty = (wr_q == rd_q);
    wr_d  = wr_q + (AW+1)'(i_in_valid && !full);
    rd_d  = rd_q + (AW+1)'(i_out_ready && !empty);
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  // Storage has no reset, only the pointers matter
  always_ff @(posedge i_ref_clk)
  begin
    if (i_in_valid && !full)
      mem[wr_q[AW-1:0]] <= i_in_data;
  end

  assign o_in_ready  = !full;
  assign o_out_valid = !empty;
  assign o_out_data  = mem[rd_q[AW-1:0]];
endmodule

// ****************************************
// Test pattern generator
// ****************************************
module tpg_top #(
  parameter int IMG_W  = 3264,
  parameter int IMG_H  = 2448,
  parameter int PIX_W  = 10,
  parameter int SQ_LG  = 4,
  parameter int BAND_H = 64,
  parameter int BAND_S = 16,
  parameter int DEPTH  = 32
) (
  // Clock and reset
  input  wire logic             i_ref_clk,
  input  wire logic             i_rstn,
  // Register port
  input  wire logic [15:0]      i_reg_addr,
  input  wire logic             i_reg_wr,
  input  wire logic [7:0]       i_reg_wdata,
  input  wire logic             i_reg_rd,
  output logic [7:0]            o_reg_rdata,
  // Sensor pixels in
  input  wire logic             i_pix_valid,
  output logic                  o_pix_ready,
  input  wire logic [PIX_W-1:0] i_pix_data,
  input  wire logic             i_pix_sof,
  input  wire logic             i_pix_sol,
  input  wire logic             i_pix_keep,
  // Pixels out
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [PIX_W-1:0]      o_out_data,
  output logic                  o_out_sof,
  output logic                  o_out_sol
);
  localparam int BAR_W = IMG_W / 8;

  logic [7:0]       ctl_q, ctl_d, opt_q, opt_d, rdata_q, rdata_d;
  logic [11:0]      x_q, x_d, y_q, y_d, band_q, band_d;
  logic [15:0]      lfsr_q, lfsr_d;
  logic             st_vld_q, st_vld_d, st_sof_q, st_sof_d;
  logic             st_sol_q, st_sol_d;
  logic [PIX_W-1:0] st_data_q, st_data_d;
  logic             f_ready, accept, pass;
  logic [11:0]      cx, cy;
  logic [12:0]      band_end;
  logic [15:0]      lfsr_base;
  logic [PIX_W-1:0] pat, outv;
  logic [PIX_W:0]   blend;
  tpg_pkg::tpg_mode_t  mode;
  tpg_pkg::tpg_style_t style;

  // Bar colour as RGB bits, white down to black
  function automatic logic [2:0] bar_rgb(input logic [2:0] idx);
    logic [2:0] c;
    c = 3'h0;
    unique case (idx)
      3'h0: c = 3'h7;
      3'h1: c = 3'h6;
      3'h2: c = 3'h3;
      3'h3: c = 3'h2;
      3'h4: c = 3'h5;
      3'h5: c = 3'h4;
      3'h6: c = 3'h1;
      3'h7: c = 3'h0;
    endcase
    return c;
  endfunction

  // Pick the Bayer channel (BG/GR rows) from an RGB colour
  function automatic logic [PIX_W-1:0] bayer(input logic [2:0] rgb,
                                             input logic xo,
                                             input logic yo);
    logic on;
    on = (!yo && !xo) ? rgb[0] : ((yo && xo) ? rgb[2] : rgb[1]);
    return on ? PIX_W'(`TPG_PIX_MAX) : '0;
  endfunction

  // Linear shading: zero loss at pos 0, black at size
  function automatic logic [PIX_W-1:0] dim(input logic [PIX_W-1:0] v,
                                           input logic [11:0] pos,
                                           input logic [11:0] size);
    logic [21:0] p;
    p = 22'(v) * 22'(pos);
    return v - PIX_W'(p / 22'(size));
  endfunction

  function automatic logic [15:0] lfsr_step(input logic [15:0] l);
    return {l[14:0], l[15] ^ l[13] ^ l[12] ^ l[10]};
  endfunction

  assign mode  = tpg_pkg::tpg_mode_t'(
                   ctl_q[`TPG_CTL_MODE_HI:`TPG_CTL_MODE_LO]);
  assign style = tpg_pkg::tpg_style_t'(
                   ctl_q[`TPG_CTL_STYLE_HI:`TPG_CTL_STYLE_LO]);
  assign o_pix_ready = !st_vld_q || f_ready;
  assign accept      = i_pix_valid && o_pix_ready;
  // Redundant pixels never reach the buffer when cut
  assign pass = accept && (i_pix_keep || !opt_q[`TPG_OPT_CUT]);

  // ****************************************
  // Registers
  // ****************************************
  always_comb
  begin
    ctl_d   = ctl_q;
    opt_d   = opt_q;
    rdata_d = rdata_q;
    if (i_reg_wr && i_reg_addr == `TPG_PATTERN_CONTROL_ADDR)
      ctl_d = i_reg_wdata;
    if (i_reg_wr && i_reg_addr == `TPG_PATTERN_OPTIONS_ADDR)
      opt_d = {1'b0, i_reg_wdata[6:0]};
    if (i_reg_rd)
      rdata_d = (i_reg_addr == `TPG_PATTERN_CONTROL_ADDR) ? ctl_q :
                (i_reg_addr == `TPG_PATTERN_OPTIONS_ADDR) ? opt_q : 8'h00;
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      ctl_q   <= `TPG_PATTERN_CONTROL_RST;
      opt_q   <= `TPG_PATTERN_OPTIONS_RST;
      rdata_q <= 8'h00;
    end
    else
    begin
      ctl_q   <= ctl_d;
      opt_q   <= opt_d;
      rdata_q <= rdata_d;
    end
  end
  assign o_reg_rdata = rdata_q;

  // ****************************************
  // Pattern path
  // ****************************************
  always_comb
  begin
    // Position follows the sensor's own frame marks
    cx = (i_pix_sof || i_pix_sol) ? 12'h000 : x_q;
    cy = i_pix_sof ? 12'h000 : (i_pix_sol ? y_q + 12'h001 : y_q);
    // Same seed restarts every frame, else run on
    lfsr_base = (i_pix_sof && opt_q[`TPG_OPT_SAME_SEED]) ?
                {`TPG_SEED_FILL,
                 opt_q[`TPG_OPT_SEED_HI:`TPG_OPT_SEED_LO]} : lfsr_q;
    pat = '0;
    unique case (mode)
      tpg_pkg::TPG_BARS:
      begin
        pat = bayer(bar_rgb(3'(cx / 12'(BAR_W))), cx[0], cy[0]);
        unique case (style)
          tpg_pkg::TPG_BAR_FLAT:       pat = pat;
          tpg_pkg::TPG_BAR_TOP_DOWN:   pat = dim(pat, cy, 12'(IMG_H));
          tpg_pkg::TPG_BAR_RIGHT_LEFT:
            pat = dim(pat, 12'(IMG_W - 1) - cx, 12'(IMG_W));
          tpg_pkg::TPG_BAR_BOTTOM_UP:
            pat = dim(pat, 12'(IMG_H - 1) - cy, 12'(IMG_H));
        endcase
      end
      tpg_pkg::TPG_RANDOM: pat = lfsr_base[PIX_W-1:0];
      tpg_pkg::TPG_SQUARE:
        if (ctl_q[`TPG_CTL_SQ_MONO])
          pat = (cx[SQ_LG] ^ cy[SQ_LG]) ? PIX_W'(`TPG_PIX_MAX) : '0;
        else
          pat = bayer(bar_rgb(cx[SQ_LG+2:SQ_LG] + cy[SQ_LG+2:SQ_LG]),
                      cx[0], cy[0]);
      tpg_pkg::TPG_BLACK: pat = '0;
    endcase
    blend = {1'b0, pat} + {1'b0, i_pix_data};
    if (ctl_q[`TPG_CTL_TRANSP])
      pat = blend[PIX_W:1];
    band_end = {1'b0, band_q} + 13'(BAND_H);
    if (ctl_q[`TPG_CTL_ROLL] && cy >= band_q && {1'b0, cy} < band_end)
      pat = ~pat;
    outv = ctl_q[`TPG_CTL_ENABLE] ? pat : i_pix_data;
    if (opt_q[`TPG_OPT_LSB_CLR])
      outv[1:0] = 2'b00;

    x_d    = accept ? cx + 12'h001 : x_q;
    y_d    = accept ? cy : y_q;
    lfsr_d = accept ? lfsr_step(lfsr_base) : lfsr_q;
    band_d = band_q;
    if (accept && i_pix_sof && ctl_q[`TPG_CTL_ROLL])
      band_d = (band_q + 12'(BAND_S) >= 12'(IMG_H)) ? 12'h000 :
               band_q + 12'(BAND_S);

    st_vld_d  = st_vld_q && !f_ready;
    st_data_d = st_data_q;
    st_sof_d  = st_sof_q;
    st_sol_d  = st_sol_q;
    if (pass)
    begin
      st_vld_d  = 1'b1;
      st_data_d = outv;
      st_sof_d  = i_pix_sof;
      st_sol_d  = i_pix_sol;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      x_q       <= 12'h000;
      y_q       <= 12'h000;
      band_q    <= 12'h000;
      lfsr_q    <= `TPG_LFSR_RST;
      st_vld_q  <= 1'b0;
      st_data_q <= '0;
      st_sof_q  <= 1'b0;
      st_sol_q  <= 1'b0;
    end
    else
    begin
      x_q       <= x_d;
      y_q       <= y_d;
      band_q    <= band_d;
      lfsr_q    <= lfsr_d;
      st_vld_q  <= st_vld_d;
      st_data_q <= st_data_d;
      st_sof_q  <= st_sof_d;
      st_sol_q  <= st_sol_d;
    end
  end

  tpg_fifo #(.W(PIX_W + 2), .DEPTH(DEPTH)) u_fifo (
    .i_ref_clk   (i_ref_clk),
    .i_rstn      (i_rstn),
    .i_in_valid  (st_vld_q),
    .o_in_ready  (f_ready),
    .i_in_data   ({st_sof_q, st_sol_q, st_data_q}),
    .o_out_valid (o_out_valid),
    .i_out_ready (i_out_ready),
    .o_out_data  ({o_out_sof, o_out_sol, o_out_data})
  );

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rstn);

  property p_bypass;
    pass && !ctl_q[`TPG_CTL_ENABLE] && !opt_q[`TPG_OPT_LSB_CLR]
      |=> st_vld_q && st_data_q == $past(i_pix_data);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("image data not passed through");

  property p_black;
    pass && ctl_q[7] && mode == tpg_pkg::TPG_BLACK && ctl_q[6:5] == 2'b00
      |=> st_data_q == '0;
  endproperty
  a_black: assert property (p_black)
    else $error("black image not black");

  property p_first_bar;
    pass && ctl_q == 8'h80 && cx < 12'(BAR_W) && !opt_q[5]
      |=> st_data_q == PIX_W'(`TPG_PIX_MAX);
  endproperty
  a_first_bar: assert property (p_first_bar)
    else $error("first flat bar not white");

  property p_mono;
    pass && ctl_q[7:4] == 4'h9 && mode == tpg_pkg::TPG_SQUARE
      && !opt_q[5] |=> st_data_q == '0 || st_data_q == PIX_W'(`TPG_PIX_MAX);
  endproperty
  a_mono: assert property (p_mono)
    else $error("mono square has grey level");

  property p_transp;
    pass && ctl_q[7:5] == 3'b101 && mode == tpg_pkg::TPG_BLACK && !opt_q[5]
      |=> st_data_q == ($past(i_pix_data) >> 1);
  endproperty
  a_transp: assert property (p_transp)
    else $error("transparent blend wrong");

  property p_roll;
    accept && i_pix_sof && ctl_q[6] |=> band_q != $past(band_q);
  endproperty
  a_roll: assert property (p_roll)
    else $error("band did not move");

  property p_seed;
    accept && i_pix_sof && opt_q[4] |=> lfsr_q ==
      lfsr_step({`TPG_SEED_FILL, $past(opt_q[3:0])});
  endproperty
  a_seed: assert property (p_seed)
    else $error("seed not reloaded");

  property p_run_on;
    accept && !opt_q[4] |=> lfsr_q == lfsr_step($past(lfsr_q));
  endproperty
  a_run_on: assert property (p_run_on)
    else $error("random state reloaded");

  property p_lsb;
    pass && opt_q[5] |=> st_data_q[1:0] == 2'b00;
  endproperty
  a_lsb: assert property (p_lsb)
    else $error("low bits not cleared");

  property p_cut;
    accept && opt_q[6] && !i_pix_keep |=> !st_vld_q;
  endproperty
  a_cut: assert property (p_cut)
    else $error("redundant pixel kept");

  property p_sof;
    pass && i_pix_sof |=> st_sof_q;
  endproperty
  a_sof: assert property (p_sof)
    else $error("frame start lost");

  c_full: cover property (st_vld_q && !f_ready);
  c_roll: cover property (accept && i_pix_sof && ctl_q[7:6] == 2'b11);
  c_rand: cover property (pass && ctl_q[7] && mode == tpg_pkg::TPG_RANDOM);
endmodule

// ===== testbench/tpg_sink.sv
`timescale 1ns/100ps

// ****************************************
// Downstream pixel sink
// ****************************************
module tpg_sink (
  // Clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rstn,
  // Pixel stream
  input  wire logic       i_valid,
  output logic            o_ready,
  input  wire logic [9:0] i_data,
  input  wire logic       i_sof,
  input  wire logic       i_sol,
  // Control
  input  wire logic       i_stall
);
  logic [11:0] got[$];
  int          seed = 30;

  // Random gaps so the buffer sees both fast and slow drains
  always @(posedge i_ref_clk)
  begin
    if (i_valid === 1'b1 && o_ready)
      got.push_back({i_sof, i_sol, i_data});
    o_ready <= !i_stall && i_rstn && ($random(seed) % 4 != 0);
  end
endmodule

// ===== testbench/test_image_test_pattern_generator.sv
`timescale 1ns/100ps

module test_image_test_pattern_generator;
  localparam int W = 16;
  localparam int H = 4;
  logic        clk, rstn, wr, rd, pv, sof, sol, keep, pr;
  logic        ov, ordy, osof, osol, stall;
  logic [15:0] addr;
  logic [7:0]  wd, rdat;
  logic [9:0]  pd, od;
  logic [11:0] exp_q[$];
  logic [11:0] fr[$];
  int          n_mismatch = 0;
  int          n_checks = 0;
  int          seed = 30;

  // Small squares and a slow short band so both show in a 16x4 frame
  tpg_top #(.IMG_W(W), .IMG_H(H), .SQ_LG(1),
            .BAND_H(2), .BAND_S(1)) dut_u (
    .i_ref_clk(clk), .i_rstn(rstn), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_wdata(wd), .i_reg_rd(rd), .o_reg_rdata(rdat),
    .i_pix_valid(pv), .o_pix_ready(pr), .i_pix_data(pd),
    .i_pix_sof(sof), .i_pix_sol(sol), .i_pix_keep(keep),
    .o_out_valid(ov), .i_out_ready(ordy), .o_out_data(od),
    .o_out_sof(osof), .o_out_sol(osol));

  tpg_sink sink_u (
    .i_ref_clk(clk), .i_rstn(rstn), .i_valid(ov), .o_ready(ordy),
    .i_data(od), .i_sof(osof), .i_sol(osol), .i_stall(stall));

  // ****************************************
  // Checking and ending
  // ****************************************
  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  function automatic logic [9:0] exp_pix(logic [9:0] d, logic [7:0] c,
                                         logic [7:0] o);
    logic [9:0] v;
    v = d;
    if (c[7])
      v = c[5] ? (d >> 1) : 10'h000;
    if (o[5])
      v[1:0] = 2'b00;
    return v;
  endfunction

  // Neighbour pairs in a row that differ; colour squares mix channels
  function automatic int pair_diffs();
    int c;
    c = 0;
    for (int i = 0; i + 1 < W * H; i += 2)
      c += (sink_u.got[i][9:0] !== sink_u.got[i + 1][9:0]);
    return c;
  endfunction

  // Shading seen at top-left a, top bar six b, bottom-left c
  function automatic bit shade_ok(int s, logic [9:0] a, logic [9:0] b,
                                  logic [9:0] c);
    if (s == 0)
      return a == 10'h3FF && b == 10'h3FF;
    if (s == 1)
      return c < a;
    if (s == 2)
      return a < b;
    return a < c;
  endfunction

  // ****************************************
  // Bus and stream drivers
  // ****************************************
  task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic reg_chk(input logic [15:0] a, input logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    check({4'h0, rdat}, {4'h0, e});
  endtask

  // One frame of random sensor data; expected words queued alongside
  task automatic frame(input logic [7:0] c, input logic [7:0] o,
                       input bit chk);
    logic [9:0] d;
    logic       k, f, l;
    reg_wr(16'h5E00, c);
    reg_wr(16'h5E01, o);
    sink_u.got.delete();
    exp_q.delete();
    for (int y = 0; y < H; y++)
      for (int x = 0; x < W; x++)
      begin
        d = 10'($random(seed));
        f = (x == 0 && y == 0);
        l = (x == 0);
        k = l | 1'($random(seed));
        pv <= 1'b1;
        pd <= d;
        sof <= f;
        sol <= l;
        keep <= k;
        do @(posedge clk); while (pr !== 1'b1);
        if (k || !o[6])
          exp_q.push_back({f, l, exp_pix(d, c, o)});
      end
    pv <= 1'b0;
    for (int i = 0; i < 3000 && sink_u.got.size() < exp_q.size(); i++)
      @(posedge clk);
    check(12'(sink_u.got.size()), 12'(exp_q.size()));
    if (chk)
      foreach (exp_q[i])
        check(sink_u.got[i], exp_q[i]);
  endtask

  // Two random frames, equal or not as the options predict
  task automatic rnd_pair(input logic [7:0] o1, input logic [7:0] o2,
                          input bit same);
    bit eq;
    frame(8'h81, o1, 0);
    fr = sink_u.got;
    frame(8'h81, o2, 0);
    eq = (fr.size() == sink_u.got.size());
    foreach (fr[i])
      if (i < sink_u.got.size() && fr[i] !== sink_u.got[i])
        eq = 1'b0;
    check({11'h0, eq}, {11'h0, same});
  endtask

  // ****************************************
  // Clock, watchdog and main sequence
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial
  begin
    // Several times the few thousand cycles the sequence needs
    #(20 * 20000);
    n_mismatch++;
    stop_test();
  end

  initial
  begin
    int n;
    bit ok;
    {rstn, wr, rd, pv, sof, sol, keep, stall} = '0;
    addr = 16'h0000;
    wd = 8'h00;
    pd = 10'h000;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    reg_chk(16'h5E00, 8'h00);
    reg_chk(16'h5E01, 8'h41);
    reg_chk(16'h5E02, 8'h00);
    reg_wr(16'h5E01, 8'hFF);
    reg_chk(16'h5E01, 8'h7F);
    reg_wr(16'h5E00, 8'hA5);
    reg_chk(16'h5E00, 8'hA5);
    frame(8'h00, 8'h41, 1);
    frame(8'h00, 8'h20, 1);
    frame(8'h83, 8'h00, 1);
    frame(8'hA3, 8'h60, 1);
    frame(8'hA3, 8'h40, 1);
    frame(8'h03, 8'h00, 1);
    for (int s = 0; s < 4; s++)
    begin
      frame({4'h8, 2'(s), 2'b00}, 8'h00, 0);
      ok = shade_ok(s, sink_u.got[0][9:0], sink_u.got[6 * W / 8][9:0],
                    sink_u.got[(H - 1) * W][9:0]);
      check({11'h0, ok}, 12'h001);
    end
    frame(8'h82, 8'h00, 0);
    check({11'h0, pair_diffs() != 0}, 12'h001);
    frame(8'h92, 8'h00, 0);
    check({11'h0, pair_diffs() == 0}, 12'h001);
    check({2'h0, sink_u.got[0][9:0] ^ sink_u.got[2][9:0]}, 12'h3FF);
    frame(8'hC3, 8'h00, 0);
    n = 0;
    foreach (sink_u.got[i])
      n += (sink_u.got[i][9:0] === 10'h3FF);
    check({11'h0, n != 0}, 12'h001);
    rnd_pair(8'h15, 8'h15, 1);
    rnd_pair(8'h13, 8'h14, 0);
    rnd_pair(8'h05, 8'h05, 0);
    // Buffer fill against a stalled sink, then full drain
    frame(8'h00, 8'h00, 1);
    sink_u.got.delete();
    stall <= 1'b1;
    pv <= 1'b1;
    {sof, sol, keep} <= 3'b001;
    n = 0;
    repeat (40)
    begin
      @(posedge clk);
      n += (pr === 1'b1);
    end
    pv <= 1'b0;
    check(12'(n), 12'h021);
    stall <= 1'b0;
    for (int i = 0; i < 500 && sink_u.got.size() < 33; i++)
      @(posedge clk);
    check(12'(sink_u.got.size()), 12'h021);
    stop_test();
  end
endmodule
